// ### rtl/plb_slave.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// R01: slave only, scl up to 400 kHz
// R02: master writes start, address, two bytes, stop
// R03: pull sda low in ack slots
// R04: answer address 1010100 with write bit
// R05: word fields trigger, power, burst, freq, ratio, level, resistor
// R06: reset word defaults to 0x0490
// R07: trigger high enables sensing
// R08: power low shuts down, trigger selects standby/active
// R09: burst holds sixteen times code plus one pulses
// R10: frequency code picks 12.5 to 100 kHz, 50% duty
// R11: ratio code sets burst to off 1:16..1:256
// R12: level code selects one of sixteen thresholds
// R13: resistor code selects open, 100k, 300k, 500k
// R14: hold bursts for start-up delay after shutdown
// R15: detect updated at last pulse of burst
// R16: high byte first, commit on second ack
// R17: mismatch or read leaves sda released
module plb_slave #(
    parameter int STARTUP_CYCLES = plb_pkg::STARTUP_CYC
) (
    input wire logic sys_clk, // 200 MHz clock
    input wire logic rst, // async reset, active high
    input wire logic scl_in, // i2c clock pin
    input wire logic sda_in, // i2c data pin level
    output logic sda_out, // i2c data drive level
    output logic sda_oe, // i2c data drive enable
    input wire logic compare_hit, // integrator voltage above level
    output logic led_drive_out, // led pulse output
    output logic detect_out, // detect level, low when object seen
    output logic sense_trigger, // trigger field
    output logic power_on, // power field
    output logic [3:0] compare_level_code, // threshold select
    output logic [1:0] filter_res_code, // filter resistor select
    output logic startup_busy // start-up delay running, or standby with trigger low
);
    typedef enum {I_IDLE, I_ADDR, I_AACK, I_DATA, I_DACK, I_IGNORE} plb_i2c_type;
    plb_i2c_type st;
    plb_pkg::plb_cfg_type sensor_control_word;
    logic [1:0] scl_sync, sda_sync;
    logic scl_d, sda_d;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] hi_byte;
    logic byte_idx;
    logic ack_drive;
    // second sync stage only feeds logic
    wire scl_s = scl_sync[1];
    wire sda_s = sda_sync[1];
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;
    wire addr_match = (shreg[7:1] == plb_pkg::SLAVE_ADDR) && !shreg[0]; // R04 R17
    wire [7:0] next_shreg = {shreg[6:0], sda_s};
    assign sda_out = 1'b0; // R03
    assign sda_oe = ack_drive; // R03
    assign sense_trigger = sensor_control_word.sense_trigger; // R07
    assign power_on = sensor_control_word.power_on;
    assign compare_level_code = sensor_control_word.compare_level_code; // R12
    assign filter_res_code = sensor_control_word.filter_res_code; // R13

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // byte shifting on rising scl, ack drive changes on falling scl (R01 slave only)
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= I_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h0;
            hi_byte <= 8'h0;
            byte_idx <= 1'b0;
            ack_drive <= 1'b0;
            sensor_control_word <= plb_pkg::CFG_RESET; // R06
        end else if (start_cond) begin
            st <= I_ADDR; // R02
            bit_cnt <= 4'h0;
            ack_drive <= 1'b0;
        end else if (stop_cond) begin
            st <= I_IDLE;
            ack_drive <= 1'b0;
        end else begin
            unique case (st)
                I_IDLE, I_IGNORE: ack_drive <= 1'b0; // R17
                I_ADDR, I_DATA: begin
                    if (scl_rise) begin
                        shreg <= next_shreg;
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    if (scl_fall && bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        if (st == I_ADDR) begin
                            if (addr_match) begin
                                st <= I_AACK;
                                ack_drive <= 1'b1; // R03
                                byte_idx <= 1'b0;
                            end else st <= I_IGNORE; // R17
                        end else begin
                            st <= I_DACK;
                            ack_drive <= 1'b1; // R03
                            if (!byte_idx) hi_byte <= shreg; // R16
                            else sensor_control_word <= {hi_byte, shreg}; // R05 R16
                        end
                    end
                end
                I_AACK, I_DACK: begin
                    if (scl_fall) begin
                        ack_drive <= 1'b0;
                        if (st == I_DACK) begin
                            byte_idx <= ~byte_idx;
                            st <= byte_idx ? I_IGNORE : I_DATA;
                        end else st <= I_DATA;
                    end
                end
            endcase
        end
    end

    plb_burst #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_burst (
        .sys_clk(sys_clk),
        .rst(rst),
        .cfg(sensor_control_word),
        .compare_hit(compare_hit),
        .led_drive_out(led_drive_out),
        .detect_n(detect_out),
        .in_startup(startup_busy)
    );

    property p_ack_only_addr;
        @(posedge sys_clk) disable iff (rst)
            (st == I_ADDR && scl_fall && bit_cnt == 4'h8 && !addr_match) |=> !sda_oe;
    endproperty
    a_ack_only_addr: assert property (p_ack_only_addr) else $error("ack on mismatch"); // R17
    property p_ack_match;
        @(posedge sys_clk) disable iff (rst)
            (st == I_ADDR && scl_fall && bit_cnt == 4'h8 && addr_match && !start_cond
             && !stop_cond) |=> sda_oe && !sda_out;
    endproperty
    a_ack_match: assert property (p_ack_match) else $error("no ack on match"); // R03 R04
    property p_commit;
        @(posedge sys_clk) disable iff (rst)
            (st == I_DATA && byte_idx && scl_fall && bit_cnt == 4'h8 && !start_cond
             && !stop_cond) |=> sensor_control_word == {$past(hi_byte), $past(shreg)};
    endproperty
    a_commit: assert property (p_commit) else $error("word not committed"); // R16
    property p_stable;
        @(posedge sys_clk) disable iff (rst)
            !(st == I_DATA && byte_idx) |=> $stable(sensor_control_word);
    endproperty
    a_stable: assert property (p_stable) else $error("word changed outside commit"); // R05
    property p_idle_release;
        @(posedge sys_clk) disable iff (rst) st == I_IGNORE |=> !sda_oe;
    endproperty
    a_idle_release: assert property (p_idle_release) else $error("sda held while ignoring"); // R17
    c_write: cover property (@(posedge sys_clk) disable iff (rst) st == I_DACK && byte_idx);
    c_miss: cover property (@(posedge sys_clk) disable iff (rst) st == I_IGNORE);
    c_led: cover property (@(posedge sys_clk) disable iff (rst) led_drive_out);
endmodule // plb_slave
`default_nettype wire

// ### include/plb_pkg.sv
`default_nettype none
package plb_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam logic [6:0] SLAVE_ADDR = 7'h54;
    localparam int STARTUP_NS = 1_300_000;
    localparam int STARTUP_CYC = STARTUP_NS / (1_000_000_000 / CLK_HZ);
    localparam logic [15:0] CFG_RESET = 16'h0490;
    localparam int FREQ_BASE_HZ = 12_500;
    localparam int HALF_BASE_CYC = CLK_HZ / (2 * FREQ_BASE_HZ);
    localparam int PULSES_PER_STEP = 16;
    localparam int CNT_W = 18;

    typedef struct packed {
        logic sense_trigger;
        logic power_on;
        logic [3:0] burst_length_code;
        logic [1:0] freq_code;
        logic [1:0] burst_off_ratio_code;
        logic [3:0] compare_level_code;
        logic [1:0] filter_res_code;
    } plb_cfg_type;
endpackage
`default_nettype wire

// ### rtl/plb_burst.sv
`timescale 1ns/100ps
`default_nettype none
module plb_burst #(
    parameter int STARTUP_CYCLES = plb_pkg::STARTUP_CYC
) (
    input wire logic sys_clk, // clock
    input wire logic rst, // async reset
    input wire plb_pkg::plb_cfg_type cfg, // configuration
    input wire logic compare_hit, // integrator above level
    output logic led_drive_out, // led pulse
    output logic detect_n, // low while object seen
    output logic in_startup // start-up delay running, or standby with trigger low
);
    typedef enum {ST_OFF, ST_WAIT, ST_ON, ST_IDLE} plb_st_type;
    plb_st_type st;
    logic [31:0] wait_cnt;
    logic [plb_pkg::CNT_W-1:0] half_cnt;
    logic [8:0] pulse_cnt;
    // off period reaches burst length times 255, wider than the burst counter
    logic [31:0] off_cnt;
    logic phase;
    wire active = cfg.power_on & cfg.sense_trigger; // R08
    wire [plb_pkg::CNT_W-1:0] half_len =
        plb_pkg::CNT_W'(plb_pkg::HALF_BASE_CYC) >> cfg.freq_code; // R10
    wire [8:0] pulse_total =
        9'(({5'h0, cfg.burst_length_code} + 9'h1) * 9'(plb_pkg::PULSES_PER_STEP)); // R09
    wire [4:0] ratio_sh = (cfg.burst_off_ratio_code == 2'h0) ? 5'h4 :
        (5'h5 + {3'h0, cfg.burst_off_ratio_code}); // R11
    wire [plb_pkg::CNT_W+4:0] burst_len = (plb_pkg::CNT_W+5)'(pulse_total) *
        (plb_pkg::CNT_W+5)'(half_len) * (plb_pkg::CNT_W+5)'(2);
    wire [31:0] off_len = (32'(burst_len) << ratio_sh) - 32'(burst_len); // R11
    wire half_done = (half_cnt == half_len - 1'b1);
    wire last_pulse = half_done && phase && (pulse_cnt == pulse_total - 9'h1);
    assign in_startup = (st == ST_WAIT);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= ST_OFF;
            wait_cnt <= 32'h0;
            half_cnt <= '0;
            pulse_cnt <= 9'h0;
            off_cnt <= '0;
            phase <= 1'b0;
            led_drive_out <= 1'b0;
            detect_n <= 1'b1;
        end else if (!cfg.power_on) begin
            st <= ST_OFF;
            led_drive_out <= 1'b0;
            phase <= 1'b0;
        end else begin
            unique case (st)
                ST_OFF: begin
                    wait_cnt <= 32'h0;
                    st <= ST_WAIT; // R14 timer starts on power-up
                end
                ST_WAIT: begin
                    if (wait_cnt < 32'(STARTUP_CYCLES)) wait_cnt <= wait_cnt + 32'h1;
                    else if (active) begin // R14
                        st <= ST_ON;
                        half_cnt <= '0;
                        pulse_cnt <= 9'h0;
                        phase <= 1'b0;
                    end
                end
                ST_ON: begin
                    led_drive_out <= ~phase & active; // R07
                    half_cnt <= half_done ? '0 : half_cnt + 1'b1;
                    if (half_done) begin
                        phase <= ~phase;
                        if (phase) pulse_cnt <= pulse_cnt + 9'h1;
                    end
                    if (last_pulse) begin
                        detect_n <= ~compare_hit; // R15
                        st <= ST_IDLE;
                        off_cnt <= '0;
                        led_drive_out <= 1'b0;
                    end
                    if (!active) begin
                        st <= ST_WAIT;
                        led_drive_out <= 1'b0;
                    end
                end
                ST_IDLE: begin
                    off_cnt <= off_cnt + 32'h1;
                    if (!active) st <= ST_WAIT;
                    else if (off_cnt >= off_len) begin
                        st <= ST_ON;
                        half_cnt <= '0;
                        pulse_cnt <= 9'h0;
                        phase <= 1'b0;
                    end
                end
            endcase
        end
    end

    property p_no_led_startup;
        @(posedge sys_clk) disable iff (rst) in_startup |=> !led_drive_out;
    endproperty
    a_no_led_startup: assert property (p_no_led_startup) else $error("led during start-up"); // R14
    property p_no_led_off;
        @(posedge sys_clk) disable iff (rst) !cfg.power_on |=> !led_drive_out;
    endproperty
    a_no_led_off: assert property (p_no_led_off) else $error("led in shutdown"); // R08
    property p_detect_at_end;
        @(posedge sys_clk) disable iff (rst)
            (st == ST_ON && last_pulse && active && cfg.power_on) |=> detect_n == !$past(compare_hit);
    endproperty
    a_detect_at_end: assert property (p_detect_at_end) else $error("detect not updated"); // R15
    c_burst: cover property (@(posedge sys_clk) disable iff (rst) st == ST_ON ##1 st == ST_IDLE);
endmodule // plb_burst
`default_nettype wire

// ### testbench/plb_i2c_master.sv
`timescale 1ns/100ps
`default_nettype none
// i2c master, 48 ns scl period; scl stands high outside frames
module plb_i2c_master (
    output logic scl, // clock to slave
    output logic sda_drv_n, // low pulls data line down
    input wire logic sda // resolved data line
);
    initial begin
        scl = 1'b1;
        sda_drv_n = 1'b1;
    end
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_drv_n = b[i];
            #12 scl = 1'b1;
            #24 scl = 1'b0;
            #12;
        end
        sda_drv_n = 1'b1;
        #12 scl = 1'b1;
        #12 ack = sda;
        #12 scl = 1'b0;
        #12;
    endtask
    // bytes beyond n are not sent; their ack bits read as 1
    task automatic frame(input logic [6:0] a, input logic rw, input logic [23:0] d,
                         input int n, output logic [3:0] acks);
        acks = 4'hf;
        sda_drv_n = 1'b0;
        #24 scl = 1'b0;
        #12;
        put_byte({a, rw}, acks[0]);
        for (int k = 0; k < n; k++) begin
            put_byte(d[23-8*k -: 8], acks[k+1]);
        end
        sda_drv_n = 1'b0;
        #12 scl = 1'b1;
        #24 sda_drv_n = 1'b1;
        #48;
    endtask
endmodule // plb_i2c_master
`default_nettype wire

// ### testbench/test_prox_led_burst_cfg_slave.sv
`timescale 1ns/100ps
`default_nettype none
module test_prox_led_burst_cfg_slave;
    logic sys_clk, rst, compare_hit, scl, sda_drv_n, sda_out, sda_oe, led_drive_out;
    logic detect_out, sense_trigger, power_on, startup_busy;
    logic [3:0] compare_level_code;
    logic [1:0] filter_res_code;
    logic [3:0] acks;
    int n_errors = 0, n_tests = 0, n, h, cnt;
    // pull-up wins unless someone drives low
    wire logic sda = sda_drv_n & ~(sda_oe & ~sda_out);
    plb_slave #(.STARTUP_CYCLES(200)) uut (.sys_clk(sys_clk), .rst(rst), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .compare_hit(compare_hit),
        .led_drive_out(led_drive_out), .detect_out(detect_out),
        .sense_trigger(sense_trigger), .power_on(power_on),
        .compare_level_code(compare_level_code), .filter_res_code(filter_res_code),
        .startup_busy(startup_busy));
    plb_i2c_master bus (.scl(scl), .sda_drv_n(sda_drv_n), .sda(sda));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic end_of_test;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cfg_chk(input logic [15:0] w);
        chk("cfg", {8'h00, w[15:14], w[5:0]},
            {8'h00, sense_trigger, power_on, compare_level_code, filter_res_code});
    endtask
    // returns lim when led never reaches v
    task automatic wt(input logic v, input int lim, output int c);
        c = 0;
        while (led_drive_out !== v && c < lim) begin
            @(posedge sys_clk);
            #1 c++;
        end
    endtask
    initial begin
        #400_000 n_errors++;
        end_of_test();
    end
    initial begin
        rst = 1'b1;
        compare_hit = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge sys_clk);
        cfg_chk(16'h0490);
        chk("reset outs", 16'h0004, {detect_out, led_drive_out, sda_oe});
        bus.frame(7'h55, 1'b0, 24'h4b1d00, 1, acks);
        chk("acks other addr", 16'h000f, acks);
        bus.frame(7'h54, 1'b1, 24'h000000, 0, acks);
        chk("acks read", 16'h000f, acks);
        cfg_chk(16'h0490);
        bus.frame(7'h54, 1'b0, 24'h0b1dff, 3, acks);
        chk("acks three bytes", 16'h0008, acks);
        cfg_chk(16'h0b1d);
        wt(1'b1, 600, n);
        chk("shutdown led", 16'd600, 16'(n));
        bus.frame(7'h54, 1'b0, 24'h3fff00, 1, acks);
        chk("acks one byte", 16'h000c, acks);
        cfg_chk(16'h0b1d);
        fork
            bus.frame(7'h54, 1'b0, 24'hc3a700, 2, acks);
            begin
                n = 0;
                while (power_on !== 1'b1 && n < 20000) begin
                    @(posedge sys_clk);
                    #1 n++;
                end
                if (n == 20000) begin
                    n_errors++;
                    end_of_test();
                end
                // burst side sees the new word at once and enters start-up on the next clock
                @(posedge sys_clk);
                #1 chk("startup busy", 16'h0001, {15'h0000, startup_busy});
                wt(1'b1, 400, n);
                // power rise seen a cycle late, so a few cycles of slack
                chk("startup hold", 16'h0001, {15'h0000, n > 197 && n < 215});
                cnt = 0;
                h = 0;
                do begin
                    wt(1'b0, 1500, n);
                    if (cnt == 0)
                        h = n;
                    cnt++;
                    wt(1'b1, 1500, n);
                end while (n < 1500);
                chk("half period", 16'(plb_pkg::HALF_BASE_CYC >> 3), 16'(h));
                chk("pulses", 16'd16, 16'(cnt));
                chk("detect", 16'h0000, {15'h0000, detect_out});
            end
        join
        chk("acks active", 16'h0008, acks);
        cfg_chk(16'hc3a7);
        end_of_test();
    end
endmodule // test_prox_led_burst_cfg_slave
`default_nettype wire
